/* File: frt_pkg.sv */
// constants, register map and field layouts of the free-running timer
// assumes a 32-bit apb slave with byte addresses in the low 8 bits
package frt_pkg;
	localparam int CNT_W = 16;
	localparam logic [7:0] OFS_CNT_HI = 8'h00;
	localparam logic [7:0] OFS_CNT_LO = 8'h04;
	localparam logic [7:0] OFS_ALT_HI = 8'h08;
	localparam logic [7:0] OFS_ALT_LO = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_CTRL1 = 8'h14;
	localparam logic [7:0] OFS_CTRL2 = 8'h18;
	localparam logic [7:0] OFS_CMP1 = 8'h1C;
	localparam logic [7:0] OFS_CMP2 = 8'h20;
	localparam logic [7:0] OFS_CAP2 = 8'h24;
	localparam logic [15:0] CNT_RELOAD = 16'hFFFC;
	localparam logic [15:0] CNT_TOP = 16'hFFFF;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
	localparam logic [15:0] CMP_RST = 16'hFFFF;
	localparam logic [1:0] CS_DIV4 = 2'h0;
	localparam logic [1:0] CS_DIV2 = 2'h1;
	localparam logic [1:0] CS_DIV8 = 2'h2;
	localparam logic [1:0] CS_EXT = 2'h3;
	localparam logic [2:0] DIV2_LAST = 3'h1;
	localparam logic [2:0] DIV4_LAST = 3'h3;
	localparam logic [2:0] DIV8_LAST = 3'h7;
	typedef struct packed {
		logic capture2Flag;
		logic capture1Flag;
		logic compare2Flag;
		logic compare1Flag;
		logic overflowFlag;
	} frt_status_t;
	typedef struct packed {
		logic captureRise2;
		logic captureRise1;
		logic compareIrqEn;
		logic captureIrqEn;
		logic overflowIrqEn;
	} frt_ctrl1_t;
	typedef struct packed {
		logic pwmMode;
		logic onePulseMode;
		logic level2;
		logic level1;
		logic [1:0] clockSel;
	} frt_ctrl2_t;
	typedef struct packed {
		logic extClk;
		logic capture2;
		logic capture1;
	} frt_pins_t;
	localparam frt_status_t STATUS_RST = 5'h00;
	localparam frt_ctrl1_t CTRL1_RST = 5'h18;
	localparam frt_ctrl2_t CTRL2_RST = 6'h00;
endpackage

/* File: frt_timer.sv */
// free-running 16-bit timer with byte views, compare pin and capture
// assumes apb master on core_clk; pins are asynchronous to core_clk
// Functional notes
// - sixteen-bit free up-counter seen as high and low byte registers
// - normal and alternate byte views always show the same count
// - writing either low byte register forces the count to FFFCh
// - reset value is FFFCh, the only value hardware ever loads
// - count clock is cpu clock over 2, 4, 8 or external clock
// - software reads high first; that read buffers the low byte
// - buffered low byte frozen until low read, despite repeated high reads
// - low read without preceding high read returns the live low byte
// - overflow flag sets when count wraps FFFFh to 0000h, any mode
// - overflow irq only when enabled and cpu mask clear, else pending
// - overflow clear: status read while set, then count_low access
// - alternate low byte accesses never clear the overflow flag
// - timer keeps counting normally during wait mode
// - halt stops the count; interrupt wake resumes, reset restarts
// - one-pulse: on compare1 match drive level1 onto compare1 pin
// - pulse period is compare1 times prescale plus five cycles; code gives (compare1 + 4) times prescale plus one
// - one-pulse never sets compare1 flag; compare2 may still interrupt
// - with pwm and one-pulse both set only pwm operates
// - equal level1 and level2 give a steady compare1 pin
// - one-pulse: capture1 edge restarts count, capture2 still captures
// - one-pulse: compare2 flags elapsed time but drives no waveform
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
module frt_timer (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire frt_pkg::frt_pins_t pinsIn,
	input wire logic cpuIrqMask,
	input wire logic haltMode,
	output logic compare1Pin,
	output logic timerIrq
);
	frt_pkg::frt_pins_t syncA_q, syncB_q, prev_q, rise, fall;
	frt_pkg::frt_status_t status_q, stSet, stClr;
	frt_pkg::frt_ctrl1_t ctrl1_q;
	frt_pkg::frt_ctrl2_t ctrl2_q;
	logic [15:0] cnt_q, cmp1_q, cmp2_q, cap2_q;
	logic [2:0] div_q, divLast;
	logic [7:0] lowBuf_q, snapLo_q;
	logic [31:0] rdVal, prdata_q;
	logic bufValid_q, armed_q, newCnt_q, pready_q, pslverr_q;
	logic compare1Pin_q, timerIrq_q, rdErr;
	logic acc, done, rd, wr, selHi, selLo, selCntLo;
	logic tick, step, load, ovfEvt, cmp1Hit, cmp2Hit;
	logic cap1Edge, cap2Edge, opmOn, pwmOn;

	// edge logic looks only at the second stage and its delayed copy prev_q
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			syncA_q <= '0;
			syncB_q <= '0;
			prev_q <= '0;
		end else if (clkEn) begin
			syncA_q <= pinsIn;
			syncB_q <= syncA_q;
			prev_q <= syncB_q;
		end
	end
	assign rise = syncB_q & ~prev_q;
	assign fall = ~syncB_q & prev_q;
	assign cap1Edge = ctrl1_q.captureRise1 ? rise.capture1 : fall.capture1;
	assign cap2Edge = ctrl1_q.captureRise2 ? rise.capture2 : fall.capture2;

	assign pwmOn = ctrl2_q.pwmMode;
	assign opmOn = ctrl2_q.onePulseMode & ~ctrl2_q.pwmMode;

	// bus effects happen at the edge where the master sees pready
	assign acc = psel & penable & ~pready_q;
	assign done = psel & penable & pready_q;
	assign rd = done & ~pwrite;
	assign wr = done & pwrite;
	assign selHi = (paddr == frt_pkg::OFS_CNT_HI) ||
		(paddr == frt_pkg::OFS_ALT_HI);
	assign selCntLo = paddr == frt_pkg::OFS_CNT_LO;
	assign selLo = selCntLo || (paddr == frt_pkg::OFS_ALT_LO);

	always_comb begin
		case (ctrl2_q.clockSel)
			frt_pkg::CS_DIV4: divLast = frt_pkg::DIV4_LAST;
			frt_pkg::CS_DIV2: divLast = frt_pkg::DIV2_LAST;
			frt_pkg::CS_DIV8: divLast = frt_pkg::DIV8_LAST;
			default: divLast = frt_pkg::DIV8_LAST;
		endcase
	end
	assign tick = (ctrl2_q.clockSel == frt_pkg::CS_EXT) ? rise.extClk :
		(div_q >= divLast);
	// wait mode has no input here: nothing but halt and clkEn gate stepping
	assign step = tick & ~haltMode;
	assign load = (wr & selLo) | (opmOn & cap1Edge) |
		(pwmOn & cmp2Hit);
	assign ovfEvt = step & ~load & (cnt_q == frt_pkg::CNT_TOP);
	assign cmp1Hit = newCnt_q & (cnt_q == cmp1_q);
	assign cmp2Hit = newCnt_q & (cnt_q == cmp2_q);

	// restarting the divider on a load makes the pulse length repeatable
	// wrap at or past the last count so a prescaler change never runs long
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			div_q <= '0;
		end else if (clkEn) begin
			if (load) begin
				div_q <= '0;
			end else if (!haltMode) begin
				div_q <= (div_q >= divLast) ? 3'h0 : div_q + 3'h1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_q <= frt_pkg::CNT_RELOAD;
			newCnt_q <= 1'b0;
		end else if (clkEn) begin
			newCnt_q <= load | step;
			if (load) begin
				cnt_q <= frt_pkg::CNT_RELOAD;
			end else if (step) begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	// pin: restart edge drives level2, compare1 match drives level1
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			compare1Pin_q <= 1'b0;
		end else if (clkEn) begin
			if ((opmOn & cap1Edge) | (pwmOn & cmp2Hit)) begin
				compare1Pin_q <= ctrl2_q.level2;
			end else if (cmp1Hit) begin
				compare1Pin_q <= ctrl2_q.level1;
			end
		end
	end

	always_comb begin
		stSet = '0;
		stSet.overflowFlag = ovfEvt;
		stSet.compare1Flag = cmp1Hit & ~opmOn;
		stSet.compare2Flag = cmp2Hit;
		stSet.capture1Flag = cap1Edge;
		stSet.capture2Flag = cap2Edge;
		stClr = '0;
		if (wr && paddr == frt_pkg::OFS_STATUS) begin
			stClr = pwdata[$bits(frt_pkg::frt_status_t)-1:0];
		end
		// only the two-step sequence clears overflow
		stClr.overflowFlag = armed_q & done & selCntLo;
	end

	// set wins over clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			status_q <= frt_pkg::STATUS_RST;
		end else if (clkEn) begin
			status_q <= (status_q & ~stClr) | stSet;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			armed_q <= 1'b0;
		end else if (clkEn) begin
			if (stClr.overflowFlag) begin
				armed_q <= 1'b0;
			end else if (rd && paddr == frt_pkg::OFS_STATUS &&
				status_q.overflowFlag) begin
				armed_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cap2_q <= '0;
		end else if (clkEn && cap2Edge) begin
			cap2_q <= cnt_q;
		end
	end

	// snapshot taken with the high byte data so both halves match
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			snapLo_q <= '0;
			lowBuf_q <= '0;
			bufValid_q <= 1'b0;
		end else if (clkEn) begin
			if (acc) begin
				snapLo_q <= cnt_q[7:0];
			end
			if (rd && selHi && !bufValid_q) begin
				lowBuf_q <= snapLo_q;
				bufValid_q <= 1'b1;
			end else if (rd && selLo) begin
				bufValid_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ctrl1_q <= frt_pkg::CTRL1_RST;
			ctrl2_q <= frt_pkg::CTRL2_RST;
			cmp1_q <= frt_pkg::CMP_RST;
			cmp2_q <= frt_pkg::CMP_RST;
		end else if (clkEn && wr) begin
			case (paddr)
				frt_pkg::OFS_CTRL1:
					ctrl1_q <= pwdata[$bits(frt_pkg::frt_ctrl1_t)-1:0];
				frt_pkg::OFS_CTRL2:
					ctrl2_q <= pwdata[$bits(frt_pkg::frt_ctrl2_t)-1:0];
				frt_pkg::OFS_CMP1: cmp1_q <= pwdata[15:0];
				frt_pkg::OFS_CMP2: cmp2_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// low read while a high read is pending returns the buffer
	always_comb begin
		rdVal = '0;
		rdErr = 1'b0;
		case (paddr)
			frt_pkg::OFS_CNT_HI, frt_pkg::OFS_ALT_HI:
				rdVal[7:0] = cnt_q[15:8];
			frt_pkg::OFS_CNT_LO, frt_pkg::OFS_ALT_LO:
				rdVal[7:0] = bufValid_q ? lowBuf_q : cnt_q[7:0];
			frt_pkg::OFS_STATUS:
				rdVal[$bits(frt_pkg::frt_status_t)-1:0] = status_q;
			frt_pkg::OFS_CTRL1:
				rdVal[$bits(frt_pkg::frt_ctrl1_t)-1:0] = ctrl1_q;
			frt_pkg::OFS_CTRL2:
				rdVal[$bits(frt_pkg::frt_ctrl2_t)-1:0] = ctrl2_q;
			frt_pkg::OFS_CMP1: rdVal[15:0] = cmp1_q;
			frt_pkg::OFS_CMP2: rdVal[15:0] = cmp2_q;
			frt_pkg::OFS_CAP2: rdVal[15:0] = cap2_q;
			default: rdErr = 1'b1;
		endcase
	end

	// one wait state: pready is registered so prdata comes from a flop
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pready_q <= 1'b0;
			prdata_q <= '0;
			pslverr_q <= 1'b0;
		end else if (clkEn) begin
			pready_q <= acc;
			if (acc) begin
				prdata_q <= pwrite ? 32'h00000000 : rdVal;
				pslverr_q <= rdErr;
			end
		end
	end

	// flags are sticky, so a masked request stays pending
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			timerIrq_q <= 1'b0;
		end else if (clkEn) begin
			timerIrq_q <= ~cpuIrqMask & (
				(status_q.overflowFlag & ctrl1_q.overflowIrqEn) |
				((status_q.capture1Flag | status_q.capture2Flag) &
				ctrl1_q.captureIrqEn) |
				((status_q.compare1Flag | status_q.compare2Flag) &
				ctrl1_q.compareIrqEn));
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign compare1Pin = compare1Pin_q;
	assign timerIrq = timerIrq_q;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n || !clkEn);

	chk_low_write_reload: assert property (
		wr && selLo |=> cnt_q == frt_pkg::CNT_RELOAD)
		else $error("low byte write did not reload count");
	chk_high_view_data: assert property (
		acc && !pwrite && selHi |=> prdata_q[7:0] == $past(cnt_q[15:8]))
		else $error("high byte view differs from count");
	chk_buffer_frozen: assert property (
		bufValid_q && !(rd && selLo) |=> $stable(lowBuf_q) && bufValid_q)
		else $error("buffered low byte changed before low read");
	chk_live_low_read: assert property (
		acc && !pwrite && selLo && !bufValid_q
		|=> prdata_q[7:0] == $past(cnt_q[7:0]))
		else $error("unbuffered low read not live");
	chk_overflow_set: assert property (
		ovfEvt |=> status_q.overflowFlag && cnt_q == frt_pkg::CNT_ZERO)
		else $error("wrap did not set overflow flag");
	chk_irq_masked: assert property (
		timerIrq_q |-> !$past(cpuIrqMask))
		else $error("interrupt raised while cpu mask set");
	chk_irq_pending: assert property (
		status_q.overflowFlag && ctrl1_q.overflowIrqEn && !cpuIrqMask
		|=> timerIrq_q)
		else $error("pending overflow not requested");
	chk_tof_two_step: assert property (
		armed_q && done && selCntLo && !ovfEvt |=> !status_q.overflowFlag)
		else $error("two-step sequence left overflow set");
	chk_alt_keeps_tof: assert property (
		done && paddr == frt_pkg::OFS_ALT_LO && status_q.overflowFlag
		|=> status_q.overflowFlag)
		else $error("alternate low access cleared overflow");
	chk_halt_holds: assert property (
		haltMode && !load |=> $stable(cnt_q))
		else $error("count moved during halt");
	chk_opm_no_cmp1: assert property (
		opmOn && !status_q.compare1Flag |=> !status_q.compare1Flag)
		else $error("compare1 flag set in one-pulse mode");
	chk_match_level1: assert property (
		cmp1Hit && !(opmOn && cap1Edge) && !(pwmOn && cmp2Hit)
		|=> compare1Pin_q == $past(ctrl2_q.level1))
		else $error("compare1 match did not drive level1");
	chk_capture2_load: assert property (
		cap2Edge |=> cap2_q == $past(cnt_q))
		else $error("capture2 did not take the count");
	chk_restart_reload: assert property (
		opmOn && cap1Edge |=> cnt_q == frt_pkg::CNT_RELOAD)
		else $error("capture1 edge did not restart count");

	cov_overflow: cover property (ovfEvt ##1 timerIrq_q);
	cov_one_pulse: cover property (opmOn && cap1Edge ##[1:600] cmp1Hit);
	cov_buffered_read: cover property (rd && selLo && bufValid_q);
	cov_pwm_reload: cover property (pwmOn && cmp2Hit);
	cov_capture2: cover property (cap2Edge);
endmodule

/* File: frt_pin_model.sv */
// board-side pin model: external count clock bursts and capture1 pulses
// assumes the bench starts and stops each burst just after core_clk edges
`timescale 1ns/100ps
module frt_pin_model (
	input wire logic core_clk,
	input wire logic extRun,
	input wire logic cap1Req,
	input wire logic cap2Req,
	output frt_pkg::frt_pins_t pinsOut
);
	logic [1:0] phase_q = 2'h0;
	logic ext_q = 1'b0;
	// one rising edge every six core clocks while a burst runs
	always @(posedge core_clk) begin
		phase_q <= (extRun && phase_q != 2'h2) ? phase_q + 2'h1 : 2'h0;
		// the external clock stands still low between bursts
		if (!extRun)
			ext_q <= 1'b0;
		else if (phase_q == 2'h2)
			ext_q <= !ext_q;
	end
	assign pinsOut = {ext_q, cap2Req, cap1Req};
endmodule

/* File: frt_timer_tb.sv */
// self-checking bench for the free-running timer, apb master inside
// assumes frt_pkg and frt_pin_model are compiled first
`timescale 1ns/100ps
module frt_timer_tb;
	typedef struct {
		logic w;
		logic [7:0] a;
		logic [31:0] d;
		logic [31:0] r;
		logic e;
	} frt_row_t;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic clkEn = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, compare1Pin, timerIrq;
	logic cpuIrqMask = 1'b1;
	logic haltMode = 1'b1;
	logic extRun = 1'b0;
	logic cap1Req = 1'b0;
	logic cap2Req = 1'b0;
	logic pinPrev;
	logic [7:0] b0, b1, d;
	frt_pkg::frt_pins_t pinsIn;
	int bad_count = 0;
	int total_checks = 0;
	int n;
	logic [1:0] ms [4] = '{frt_pkg::CS_DIV2, frt_pkg::CS_DIV4,
		frt_pkg::CS_DIV8, frt_pkg::CS_EXT};
	logic [7:0] tk [4] = '{8'h20, 8'h10, 8'h08, 8'h0B};
	// count frozen by halt, so every row is exact
	frt_row_t rows [13] = '{
		'{0, frt_pkg::OFS_CNT_HI, 0, 32'hFF, 0},
		'{0, frt_pkg::OFS_CNT_LO, 0, 32'hFC, 0},
		'{0, frt_pkg::OFS_ALT_HI, 0, 32'hFF, 0},
		'{0, frt_pkg::OFS_ALT_LO, 0, 32'hFC, 0},
		'{0, frt_pkg::OFS_STATUS, 0, 32'h00, 0},
		'{0, frt_pkg::OFS_CTRL1, 0, 32'h18, 0},
		'{0, frt_pkg::OFS_CTRL2, 0, 32'h00, 0},
		'{0, frt_pkg::OFS_CMP1, 0, 32'hFFFF, 0},
		'{0, frt_pkg::OFS_CMP2, 0, 32'hFFFF, 0},
		'{1, frt_pkg::OFS_CNT_HI, 32'h5A, 0, 0},
		'{0, frt_pkg::OFS_CNT_HI, 0, 32'hFF, 0},
		'{0, 8'h30, 0, 0, 1},
		'{1, frt_pkg::OFS_CMP2, 32'h1234, 0, 0}};

	always #5 core_clk = !core_clk;

	frt_pin_model pins (.core_clk(core_clk), .extRun(extRun),
		.cap1Req(cap1Req), .cap2Req(cap2Req), .pinsOut(pinsIn));
	frt_timer dut (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pinsIn(pinsIn), .cpuIrqMask(cpuIrqMask),
		.haltMode(haltMode), .compare1Pin(compare1Pin),
		.timerIrq(timerIrq));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] dat);
		int k;
		k = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= dat;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (k >= 16) begin
			bad_count++;
			end_of_test();
		end
	endtask

	task automatic rdr(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	initial begin
		repeat (8) @(posedge core_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			check(err, rows[i].e);
			if (!rows[i].e)
				check(rd, rows[i].r);
		end
		for (int i = 0; i < 2; i++) begin
			haltMode <= 1'b0;
			repeat (20) @(posedge core_clk);
			haltMode <= 1'b1;
			apb(1'b1, i ? frt_pkg::OFS_ALT_LO : frt_pkg::OFS_CNT_LO, 32'h0);
			rdr(frt_pkg::OFS_CNT_HI);
			check(rd, 32'hFF);
			rdr(frt_pkg::OFS_CNT_LO);
			check(rd, 32'hFC);
		end
		// second high read must not refresh the buffered low byte
		apb(1'b1, frt_pkg::OFS_CTRL2, 32'(frt_pkg::CS_DIV2));
		haltMode <= 1'b0;
		rdr(frt_pkg::OFS_CNT_HI);
		repeat (40) @(posedge core_clk);
		haltMode <= 1'b1;
		rdr(frt_pkg::OFS_CNT_HI);
		rdr(frt_pkg::OFS_CNT_LO);
		b0 = rd[7:0];
		rdr(frt_pkg::OFS_CNT_LO);
		b1 = rd[7:0];
		d = b1 - b0;
		check(d >= 8'd19 && d <= 8'd23, 1'b1);
		rdr(frt_pkg::OFS_ALT_LO);
		check(rd, {24'h0, b1});
		// clock enable low must freeze the count although halt is off
		clkEn <= 1'b0;
		haltMode <= 1'b0;
		repeat (20) @(posedge core_clk);
		clkEn <= 1'b1;
		haltMode <= 1'b1;
		rdr(frt_pkg::OFS_ALT_LO);
		check(rd, {24'h0, b1});
		extRun <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, frt_pkg::OFS_CNT_LO, 32'h0);
			apb(1'b1, frt_pkg::OFS_CTRL2, 32'(ms[i]));
			haltMode <= 1'b0;
			repeat (64) @(posedge core_clk);
			haltMode <= 1'b1;
			rdr(frt_pkg::OFS_CNT_HI);
			rdr(frt_pkg::OFS_CNT_LO);
			d = rd[7:0] - 8'hFC;
			check(d + 8'd1 >= tk[i] && d <= tk[i] + 8'd1, 1'b1);
		end
		extRun <= 1'b0;
		apb(1'b1, frt_pkg::OFS_CTRL2, 32'(frt_pkg::CS_DIV2));
		apb(1'b1, frt_pkg::OFS_CTRL1, 32'h19);
		rdr(frt_pkg::OFS_STATUS);
		rdr(frt_pkg::OFS_CNT_LO);
		rdr(frt_pkg::OFS_STATUS);
		check(rd[0], 1'b0);
		apb(1'b1, frt_pkg::OFS_CNT_LO, 32'h0);
		haltMode <= 1'b0;
		repeat (30) @(posedge core_clk);
		haltMode <= 1'b1;
		check(timerIrq, 1'b0);
		rdr(frt_pkg::OFS_STATUS);
		check(rd[0], 1'b1);
		cpuIrqMask <= 1'b0;
		repeat (3) @(posedge core_clk);
		check(timerIrq, 1'b1);
		rdr(frt_pkg::OFS_ALT_LO);
		rdr(frt_pkg::OFS_STATUS);
		check(rd[0], 1'b1);
		rdr(frt_pkg::OFS_CNT_LO);
		rdr(frt_pkg::OFS_STATUS);
		check(rd[0], 1'b0);
		check(timerIrq, 1'b0);
		apb(1'b1, frt_pkg::OFS_CMP1, 32'h0010);
		apb(1'b1, frt_pkg::OFS_CTRL2, 32'h15);
		apb(1'b1, frt_pkg::OFS_STATUS, 32'h1E);
		haltMode <= 1'b0;
		cap1Req <= 1'b1;
		repeat (2) @(posedge core_clk);
		cap1Req <= 1'b0;
		repeat (20) @(posedge core_clk);
		check(compare1Pin, 1'b0);
		repeat (40) @(posedge core_clk);
		check(compare1Pin, 1'b1);
		rdr(frt_pkg::OFS_STATUS);
		check(rd[1], 1'b0);
		check(rd[3], 1'b1);
		// equal levels: the pin may not move across a whole pulse
		apb(1'b1, frt_pkg::OFS_CTRL2, 32'h1D);
		cap1Req <= 1'b1;
		n = 0;
		repeat (80) begin
			@(posedge core_clk);
			cap1Req <= 1'b0;
			n += (compare1Pin !== 1'b1);
		end
		check(n, 0);
		// halted count gives a known value for the capture2 snapshot
		haltMode <= 1'b1;
		rdr(frt_pkg::OFS_CNT_HI);
		b0 = rd[7:0];
		rdr(frt_pkg::OFS_CNT_LO);
		b1 = rd[7:0];
		cap2Req <= 1'b1;
		repeat (2) @(posedge core_clk);
		cap2Req <= 1'b0;
		repeat (6) @(posedge core_clk);
		rdr(frt_pkg::OFS_CAP2);
		check(rd, {16'h0000, b0, b1});
		rdr(frt_pkg::OFS_STATUS);
		check(rd[4], 1'b1);
		// pwm over one-pulse: 25-cycle period gives three rising edges
		apb(1'b1, frt_pkg::OFS_CMP1, 32'h00000004);
		apb(1'b1, frt_pkg::OFS_CMP2, 32'h00000008);
		apb(1'b1, frt_pkg::OFS_CNT_LO, 32'h00000000);
		apb(1'b1, frt_pkg::OFS_CTRL2, 32'h00000035);
		haltMode <= 1'b0;
		pinPrev = compare1Pin;
		n = 0;
		repeat (100) begin
			@(posedge core_clk);
			n += (compare1Pin === 1'b1 && pinPrev === 1'b0);
			pinPrev = compare1Pin;
		end
		check(n, 3);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		rdr(frt_pkg::OFS_CNT_HI);
		check(rd, 32'hFF);
		rdr(frt_pkg::OFS_CNT_LO);
		check(rd, 32'hFC);
		end_of_test();
	end
endmodule
